//--- hw/sarc_core.sv
/*
 * Conversion control of an 18-bit differential SAR converter with a serial
 * readout side on the host's serial clock.
 * Assumes the analog front end supplies a comparator decision, range
 * detectors and a clamp indicator as pins; the host also drives linkClk
 * while linkCsN is high, between frames.
 */
`timescale 1ns/1ns
module sarc_core
    import sarc_pkg::*;
#(
    parameter int CONV_DIV_P = CONV_DIV,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Host control pins
    input wire logic conversionStartInput,
    input wire logic spanCompressEn,
    // Analog front end indications
    input wire logic compHigh,
    input wire logic overRange,
    input wire logic underRange,
    input wire logic clampActive,
    // Analog switch controls
    output logic positiveSampleGroundSwitch,
    output logic negativeSampleGroundSwitch,
    output logic [17:0] posArrayTrial,
    output logic [17:0] negArrayTrial,
    output logic spanScaleSel,
    // Status
    output logic busy,
    output logic [17:0] resultCode,
    output logic overvoltageClampFlagN,
    output logic fifoFull,
    // Serial link on the host clock
    input wire logic linkClk,
    input wire logic linkCsN,
    input wire logic linkSdi,
    output logic linkSdo,
    output logic linkSdoOe
);
    typedef enum {SAR_IDLE, SAR_OPEN, SAR_TRIAL, SAR_DONE} sarc_state_t;
    sarc_state_t state_q;

    // Pin synchronisers in the core domain
    logic [5:0] pinSync;
    logic cnvS, spanS, compS, overS, underS, clampS;
    sarc_sync #(.W(6)) uPinSync (
        .clk(core_clk),
        .asyncIn({conversionStartInput, spanCompressEn, compHigh, overRange,
                  underRange, clampActive}),
        .syncOut(pinSync)
    );
    assign {cnvS, spanS, compS, overS, underS, clampS} = pinSync;

    // Start edge detection
    logic cnvPrev_q;
    logic cnvRise;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnvPrev_q <= 1'b0;
        end else begin
            cnvPrev_q <= cnvS;
        end
    end
    assign cnvRise = cnvS && !cnvPrev_q;

    // Conversion clock divider; runs only in the trials so the first tick sees a settled top bit
    logic [7:0] divCnt_q;
    logic convTick;
    assign convTick = divCnt_q == 8'(CONV_DIV_P - 1);
    always_ff @(posedge core_clk) begin
        if (sys_rst || state_q != SAR_TRIAL) begin
            divCnt_q <= '0;
        end else if (convTick) begin
            divCnt_q <= '0;
        end else begin
            divCnt_q <= divCnt_q + 8'h01;
        end
    end

    // Sequencer state
    logic [4:0] bitIdx_q;
    logic [7:0] openCnt_q;
    logic [17:0] trial_q;
    logic over_q, under_q;
    logic fifoInReady, fifoInValid;
    logic [WORD_BITS-1:0] fifoInData;

    // Main sequence: open switches, trial each bit, finish
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= SAR_IDLE;
            openCnt_q <= '0;
        end else begin
            case (state_q)
                SAR_IDLE: begin
                    if (cnvRise && fifoInReady) begin
                        state_q <= SAR_OPEN;
                        openCnt_q <= '0;
                    end
                end
                SAR_OPEN: begin
                    openCnt_q <= openCnt_q + 8'h01;
                    if (openCnt_q == 8'(OPEN_CYC - 1)) begin
                        state_q <= SAR_TRIAL;
                    end
                end
                SAR_TRIAL: begin
                    if (convTick && bitIdx_q == 5'h00) begin
                        state_q <= SAR_DONE;
                    end
                end
                SAR_DONE: begin
                    if (fifoInReady) begin
                        state_q <= SAR_IDLE;
                    end
                end
                default: state_q <= SAR_IDLE;
            endcase
        end
    end

    // Range detectors caught at the hold instant
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            over_q <= 1'b0;
            under_q <= 1'b0;
        end else if (state_q == SAR_IDLE && cnvRise) begin
            over_q <= overS;
            under_q <= underS;
        end
    end

    // Binary search register, one decision per conversion clock
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            trial_q <= '0;
            bitIdx_q <= '0;
        end else if (state_q == SAR_OPEN) begin
            trial_q <= 18'h20000;
            bitIdx_q <= 5'(RES_BITS - 1);
        end else if (state_q == SAR_TRIAL && convTick) begin
            if (!compS) begin
                trial_q[bitIdx_q] <= 1'b0;
            end
            if (bitIdx_q != 5'h00) begin
                trial_q[bitIdx_q - 5'h01] <= 1'b1;
                bitIdx_q <= bitIdx_q - 5'h01;
            end
        end
    end

    // Offset binary to two's complement with saturation
    function automatic logic [17:0] toCode(input logic [17:0] ob, input logic ov,
                                           input logic un);
        if (ov) begin
            toCode = CODE_POS_MAX;
        end else if (un) begin
            toCode = CODE_NEG_MAX;
        end else begin
            toCode = {~ob[SIGN_POS], ob[SIGN_POS-1:0]};
        end
    endfunction : toCode

    // Latched result, replaced only by the next finished conversion
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            resultCode <= CODE_MID;
        end else if (state_q == SAR_DONE && fifoInReady) begin
            resultCode <= toCode(trial_q, over_q, under_q);
        end
    end

    // Busy from the start edge until the code is latched
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else if (state_q == SAR_IDLE && cnvRise && fifoInReady) begin
            busy <= 1'b1;
        end else if (state_q == SAR_DONE && fifoInReady) begin
            busy <= 1'b0;
        end
    end

    // Switch drive: ground switches closed while acquiring
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            positiveSampleGroundSwitch <= 1'b1;
            negativeSampleGroundSwitch <= 1'b1;
            posArrayTrial <= '0;
            negArrayTrial <= '0;
        end else begin
            positiveSampleGroundSwitch <= state_q == SAR_IDLE && !(cnvRise && fifoInReady);
            negativeSampleGroundSwitch <= state_q == SAR_IDLE && !(cnvRise && fifoInReady);
            posArrayTrial <= trial_q;
            negArrayTrial <= ~trial_q;
        end
    end

    // Reference span select, frozen during a conversion
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            spanScaleSel <= 1'b0;
        end else if (state_q == SAR_IDLE) begin
            spanScaleSel <= spanS;
        end
    end

    // Register read events arrive from the link as a toggle
    logic rdTgl_q;
    logic rdTglS, rdTglPrev_q, rdEvent;
    sarc_sync #(.W(1)) uRdSync (
        .clk(core_clk),
        .asyncIn(rdTgl_q),
        .syncOut(rdTglS)
    );
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdTglPrev_q <= 1'b0;
        end else begin
            rdTglPrev_q <= rdTglS;
        end
    end
    assign rdEvent = rdTglS != rdTglPrev_q;

    // Sticky active-low clamp flag; setting wins over clearing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            overvoltageClampFlagN <= FLAG_IDLE;
        end else if (clampS) begin
            overvoltageClampFlagN <= 1'b0;
        end else if (rdEvent) begin
            overvoltageClampFlagN <= FLAG_IDLE;
        end
    end

    // Result FIFO in front of the link
    logic fifoOutValid, fifoOutReady;
    logic [WORD_BITS-1:0] fifoOutData;
    assign fifoInValid = state_q == SAR_DONE;
    assign fifoInData = {over_q, under_q, overvoltageClampFlagN && !clampS,
                         toCode(trial_q, over_q, under_q)};
    sarc_fifo #(.WIDTH(WORD_BITS), .DEPTH(DEPTH)) uFifo (
        .clk(core_clk),
        .rst(sys_rst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    // Full indication; new starts are refused while full
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fifoFull <= 1'b0;
        end else begin
            fifoFull <= !fifoInReady;
        end
    end

    // Word handoff to the link: hold word, toggle, wait for ack toggle
    logic [WORD_BITS-1:0] xferWord_q;
    logic xferTgl_q, ackTgl_q, ackS;
    sarc_sync #(.W(1)) uAckSync (
        .clk(core_clk),
        .asyncIn(ackTgl_q),
        .syncOut(ackS)
    );
    assign fifoOutReady = fifoOutValid && (ackS == xferTgl_q);
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            xferWord_q <= '0;
            xferTgl_q <= 1'b0;
        end else if (fifoOutReady) begin
            xferWord_q <= fifoOutData;
            xferTgl_q <= ~xferTgl_q;
        end
    end

    // Link domain: reset, toggle, flag and span select crossings
    logic [3:0] linkSyncOut;
    logic linkRst, xferS, flagS, spanL;
    sarc_sync #(.W(4)) uLinkSync (
        .clk(linkClk),
        .asyncIn({sys_rst, xferTgl_q, overvoltageClampFlagN, spanScaleSel}),
        .syncOut(linkSyncOut)
    );
    assign {linkRst, xferS, flagS, spanL} = linkSyncOut;

    // Frame bit counter, shift register and mode
    logic [4:0] bitCnt_q;
    logic [DATA_FRAME_BITS-1:0] shift_q;
    logic regMode_q;
    logic frameFirst;
    assign frameFirst = !linkCsN && bitCnt_q == 5'h00;

    always_ff @(posedge linkClk) begin
        if (linkRst || linkCsN) begin
            bitCnt_q <= '0;
        end else if (bitCnt_q != 5'h1f) begin
            bitCnt_q <= bitCnt_q + 5'h01;
        end
    end

    // First edge picks register read or data read; then shift out MSB first
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            shift_q <= '0;
            regMode_q <= 1'b0;
        end else if (frameFirst) begin
            regMode_q <= linkSdi == MODE_REG;
            if (linkSdi == MODE_REG) begin
                shift_q <= '0;
                shift_q[DATA_FRAME_BITS-REG_FRAME_BITS+REG_FLAG_POS] <= flagS;
            end else begin
                shift_q <= {xferWord_q[17:0], xferWord_q[WORD_OVER_POS],
                            xferWord_q[WORD_UNDER_POS], xferWord_q[WORD_FLAG_POS],
                            spanL, 2'b00};
            end
        end else if (!linkCsN) begin
            shift_q <= {shift_q[DATA_FRAME_BITS-2:0], 1'b0};
        end
    end

    // Acknowledge the word once a data frame has taken it
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            ackTgl_q <= 1'b0;
        end else if (frameFirst && linkSdi != MODE_REG) begin
            ackTgl_q <= xferS;
        end
    end

    // Register read complete after its sixteenth bit
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            rdTgl_q <= 1'b0;
        end else if (!linkCsN && regMode_q && bitCnt_q == 5'(REG_FRAME_BITS)) begin
            rdTgl_q <= ~rdTgl_q;
        end
    end

    // Serial output and its enable
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            linkSdo <= 1'b0;
            linkSdoOe <= 1'b0;
        end else begin
            linkSdo <= shift_q[DATA_FRAME_BITS-1];
            linkSdoOe <= !linkCsN;
        end
    end
endmodule : sarc_core

//--- hw/sarc_pkg.sv
/*
 * Shared constants of the converter control block: code layout, saturation
 * codes, conversion clock timing and link frame layout.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sarc_pkg;
    // Result layout
    localparam int RES_BITS = 18;
    localparam logic [17:0] CODE_POS_MAX = 18'h1ffff;
    localparam logic [17:0] CODE_NEG_MAX = 18'h20000;
    localparam logic [17:0] CODE_MID = 18'h00000;
    localparam int SIGN_POS = 17;
    // Word stored per conversion: {overrange, underrange, flag_n, code}
    localparam int WORD_BITS = 21;
    localparam int WORD_FLAG_POS = 18;
    localparam int WORD_UNDER_POS = 19;
    localparam int WORD_OVER_POS = 20;
    // Conversion clock: one decision per period, long enough for trial, comparator and sync
    localparam int CORE_CLK_NS = 50;
    localparam int CONV_CLK_NS = 200;
    localparam int CONV_DIV = (CONV_CLK_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
    // Settling time after the sample switches open
    localparam int OPEN_NS = 50;
    localparam int OPEN_CYC = (OPEN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
    // Link frames
    localparam int REG_FRAME_BITS = 16;
    localparam int DATA_FRAME_BITS = 24;
    localparam int REG_FLAG_POS = 8;
    localparam logic MODE_REG = 1'b1;
    // Flag idle level (active low)
    localparam logic FLAG_IDLE = 1'b1;
    localparam int FIFO_DEPTH = 16;
endpackage : sarc_pkg

//--- hw/sarc_sync.sv
/*
 * Two flip-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a level that stays put for several destination edges.
 */
`timescale 1ns/1ns
module sarc_sync #(
    parameter int W = 1
) (
    // Destination clock
    input wire logic clk,
    // Levels in and out
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        meta_q <= asyncIn;
        syncOut <= meta_q;
    end
endmodule : sarc_sync

//--- hw/sarc_fifo.sv
/*
 * Result FIFO with valid/ready on both sides; read data leave a register.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
module sarc_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wPtr_q, rPtr_q;
    logic [AW:0] count_q;
    logic push, pop;

    // Full stops the filler, empty stops the output stage
    assign inReady = count_q != (AW+1)'(DEPTH);
    assign push = inValid && inReady;
    assign pop = (count_q != '0) && (!outValid || outReady);

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wPtr_q] <= inData;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (rst) begin
            wPtr_q <= '0;
            rPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wPtr_q <= wPtr_q + 1'b1;
            end
            if (pop) begin
                rPtr_q <= rPtr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Registered read stage
    always_ff @(posedge clk) begin
        if (rst) begin
            outValid <= 1'b0;
            outData <= '0;
        end else if (pop) begin
            outValid <= 1'b1;
            outData <= mem[rPtr_q];
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end
endmodule : sarc_fifo

//--- bench/sarc_core_properties.sv
/* Concurrent checks on the core-clock ports of sarc_core.
   Assumes it is bound to every sarc_core instance and sees its ports only. */
`timescale 1ns/1ns
module sarc_core_properties
    import sarc_pkg::*;
#(
    parameter int CONV_DIV_P = CONV_DIV
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Inputs watched
    input wire logic spanCompressEn,
    input wire logic overRange,
    input wire logic underRange,
    input wire logic clampActive,
    // Outputs watched
    input wire logic positiveSampleGroundSwitch,
    input wire logic negativeSampleGroundSwitch,
    input wire logic [17:0] posArrayTrial,
    input wire logic [17:0] negArrayTrial,
    input wire logic spanScaleSel,
    input wire logic busy,
    input wire logic [17:0] resultCode,
    input wire logic overvoltageClampFlagN
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    localparam int LEN_NOM = 2 + RES_BITS * CONV_DIV_P;
    int busyLen_q;
    // Counts the cycles of the current busy period
    always_ff @(posedge core_clk) begin
        if (sys_rst || !busy) busyLen_q <= 0;
        else busyLen_q <= busyLen_q + 1;
    end
    switch_open_a:
        assert property (busy |-> !positiveSampleGroundSwitch && !negativeSampleGroundSwitch)
        else $error("sample switches closed during conversion");
    conv_length_a:
        assert property ($fell(busy) |-> busyLen_q == LEN_NOM)
        else $error("conversion length off");
    trial_msb_a:
        assert property ($rose(busy) |-> ##[1:3] posArrayTrial == 18'h20000)
        else $error("first trial is not the top bit");
    array_pair_a:
        assert property (busy && $past(busy, 2) |-> negArrayTrial == ~posArrayTrial)
        else $error("arrays not matched");
    result_hold_a:
        assert property ($changed(resultCode) |-> $fell(busy))
        else $error("result changed outside completion");
    sat_pos_a:
        assert property ($fell(busy) && overRange |-> resultCode == CODE_POS_MAX)
        else $error("overrange not saturated");
    sat_neg_a:
        assert property ($fell(busy) && !overRange && underRange |-> resultCode == CODE_NEG_MAX)
        else $error("underrange not saturated");
    span_follow_a:
        assert property ((!busy && $stable(spanCompressEn))[*6] |-> spanScaleSel == spanCompressEn)
        else $error("span select does not follow");
    flag_set_a:
        assert property (clampActive |-> ##[1:4] !overvoltageClampFlagN)
        else $error("clamp flag not set");
    flag_sticky_a:
        assert property ($rose(overvoltageClampFlagN) |-> !clampActive && !$past(clampActive, 3))
        else $error("clamp flag cleared while clamp on");
    // Main scenarios
    cover property ($fell(busy));
    cover property ($fell(busy) && overRange);
    cover property ($rose(overvoltageClampFlagN));
endmodule : sarc_core_properties

bind sarc_core sarc_core_properties #(.CONV_DIV_P(CONV_DIV_P)) chk (.core_clk, .sys_rst,
    .spanCompressEn, .overRange, .underRange, .clampActive, .positiveSampleGroundSwitch,
    .negativeSampleGroundSwitch, .posArrayTrial, .negArrayTrial, .spanScaleSel, .busy,
    .resultCode, .overvoltageClampFlagN);

//--- bench/sarc_front_model.sv
/* Comparator of the analog front end facing the trial arrays.
   Assumes the trial word and the held level are both offset binary. */
`timescale 1ns/1ns
module sarc_front_model (
    // Trial word from the design
    input wire logic [17:0] posArrayTrial,
    // Held differential level
    input wire logic [17:0] level,
    // Decision
    output logic compHigh
);
    // High while the held level is at or above the trial
    assign compHigh = (level >= posArrayTrial);
endmodule : sarc_front_model

//--- bench/tb_sarc_core.sv
/* Self-checking bench of sarc_core: conversions, saturation, result FIFO,
   link reads and the clamp flag.
   Assumes the front-end model and the checker are compiled before it. */
`timescale 1ns/1ns
module tb_sarc_core;
    import sarc_pkg::*;
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin n_fail++; \
    $display("unexpected %s expected %h seen %h", nm, e, s); end end
    // Clocks, reset and host pins
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic conversionStartInput = 1'b0;
    logic spanCompressEn = 1'b0;
    logic overRange = 1'b0;
    logic underRange = 1'b0;
    logic clampActive = 1'b0;
    logic linkClk = 1'b0;
    logic linkCsN = 1'b1;
    logic linkSdi = 1'b0;
    logic [17:0] level = 18'h00000;
    // Design outputs and the front-end decision
    logic compHigh, positiveSampleGroundSwitch, negativeSampleGroundSwitch, spanScaleSel;
    logic busy, overvoltageClampFlagN, fifoFull, linkSdo, linkSdoOe;
    logic [17:0] posArrayTrial, negArrayTrial, resultCode;
    // Bookkeeping
    int n_fail = 0;
    int cmp_count = 0;
    logic [17:0] expQ[$];
    logic [17:0] linkQ[$];
    logic [17:0] expV, expMon;
    logic [23:0] word;
    logic busyPrev = 1'b0;
    logic [17:0] codes[6] = '{18'h1ffff, 18'h00000, 18'h3ffff, 18'h20000, 18'h00001, 18'h20001};

    // Core clock, 50 ns period
    initial begin
        forever #25 core_clk = ~core_clk;
    end

    sarc_core dut (.core_clk, .sys_rst, .conversionStartInput, .spanCompressEn, .compHigh,
        .overRange, .underRange, .clampActive, .positiveSampleGroundSwitch,
        .negativeSampleGroundSwitch, .posArrayTrial, .negArrayTrial, .spanScaleSel, .busy,
        .resultCode, .overvoltageClampFlagN, .fifoFull, .linkClk, .linkCsN, .linkSdi,
        .linkSdo, .linkSdoOe);
    sarc_front_model fe (.posArrayTrial, .level, .compHigh);

    // Takes the oldest noted code whenever a conversion completes
    always @(negedge core_clk) begin
        busyPrev <= busy;
        if (busyPrev === 1'b1 && busy === 1'b0) begin
            expMon = expQ.pop_front();
            `CHK("resultCode", expMon, resultCode)
        end
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    // One conversion: note the code, hold the level, raise the start pin
    task automatic convert(input logic [17:0] code, input logic ovr, input logic unr);
        logic [17:0] e;
        int n;
        e = ovr ? CODE_POS_MAX : (unr ? CODE_NEG_MAX : code);
        expQ.push_back(e);
        linkQ.push_back(e);
        @(posedge core_clk);
        level <= code ^ CODE_NEG_MAX;
        overRange <= ovr;
        underRange <= unr;
        spanCompressEn <= 1'($urandom);
        repeat (10) @(negedge core_clk);
        `CHK("spanScaleSel", spanCompressEn, spanScaleSel)
        @(posedge core_clk);
        conversionStartInput <= 1'b1;
        n = 0;
        do begin @(negedge core_clk); n++; end while (busy !== 1'b1 && n < 10);
        `CHK("convStart", 1'b1, busy)
        @(posedge core_clk);
        conversionStartInput <= 1'b0;
        n = 0;
        do begin @(negedge core_clk); n++; end while (busy !== 1'b0 && n < 100);
        `CHK("convDone", 1'b0, busy)
    endtask : convert

    // One link frame: mode bit on the first edge, then nb bits MSB first
    task automatic link_read(input logic mode, input int nb);
        word = 24'h000000;
        // Two idle edges bring the link-side crossings up to date
        repeat (2) begin #80 linkClk = 1'b1; #80 linkClk = 1'b0; end
        #37 linkCsN = 1'b0;
        linkSdi = mode;
        #80 linkClk = 1'b1;
        #80 linkClk = 1'b0;
        for (int i = 0; i < nb; i++) begin
            linkSdi = ~linkSdi; // Don't-care bits change every edge
            #80 linkClk = 1'b1;
            #80 word = {word[22:0], linkSdo};
            linkClk = 1'b0;
        end
        `CHK("linkSdoOe", 1'b1, linkSdoOe)
        linkCsN = 1'b1;
        #80 linkClk = 1'b1;
        #80 linkClk = 1'b0;
        `CHK("linkSdoOff", 1'b0, linkSdoOe)
    endtask : link_read

    // Main sequence
    initial begin
        void'($urandom(32'h9fcee51b));
        repeat (4) begin #80 linkClk = 1'b1; #80 linkClk = 1'b0; end
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        `CHK("flagReset", 1'b1, overvoltageClampFlagN)
        `CHK("codeReset", CODE_MID, resultCode)
        // Fill FIFO, its read stage and the link word: table codes, saturation, random codes
        for (int i = 0; i < FIFO_DEPTH + 2; i++) begin
            if (i < 6) convert(codes[i], 1'b0, 1'b0);
            else convert(18'($urandom), 1'(i == 6 || i == 8), 1'(i == 7 || i == 8));
        end
        @(negedge core_clk);
        `CHK("fifoFull", 1'b1, fifoFull)
        // A start while full is ignored
        @(posedge core_clk);
        conversionStartInput <= 1'b1;
        repeat (20) @(negedge core_clk);
        `CHK("refusedBusy", 1'b0, busy)
        @(posedge core_clk);
        conversionStartInput <= 1'b0;
        // Drain through data frames, oldest first
        while (linkQ.size() > 0) begin
            link_read(1'b0, DATA_FRAME_BITS);
            expV = linkQ.pop_front();
            `CHK("linkCode", expV, word[23:6])
            `CHK("linkFlag", 1'b1, word[3])
        end
        @(negedge core_clk);
        `CHK("fifoDrained", 1'b0, fifoFull)
        // Clamp flag: set, read while on, sticky, cleared by a later read
        @(posedge core_clk);
        clampActive <= 1'b1;
        repeat (6) @(negedge core_clk);
        `CHK("flagSet", 1'b0, overvoltageClampFlagN)
        link_read(MODE_REG, REG_FRAME_BITS);
        `CHK("regFlagOn", 1'b0, word[REG_FLAG_POS])
        @(posedge core_clk);
        clampActive <= 1'b0;
        repeat (10) @(negedge core_clk);
        `CHK("flagSticky", 1'b0, overvoltageClampFlagN)
        link_read(MODE_REG, REG_FRAME_BITS);
        `CHK("regFlagHeld", 1'b0, word[REG_FLAG_POS])
        repeat (10) @(negedge core_clk);
        `CHK("flagCleared", 1'b1, overvoltageClampFlagN)
        convert(18'h2aaaa, 1'b0, 1'b0);
        print_verdict();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #2000000;
        n_fail++;
        print_verdict();
    end
endmodule : tb_sarc_core
